// file: design/pit_pkg.sv
/*
  Shared constants, types and helpers for the I2C target port of the
  power-management device: address table, filter and timing counts,
  FIFO shape and the packet state enumeration.
  Assumes a 20 MHz core clock; all cycle counts derive from it.
*/
`default_nettype none

package pit_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 50;

  // Spike suppression on SCL and SDA
  localparam int SPIKE_MAX_NS = 50;
  // A level must persist longer than the widest spike
  localparam int FILT_CYC = SPIKE_MAX_NS / CLK_PERIOD_NS + 1;

  // Link timing limits of the 1 MHz mode
  localparam int SCL_MAX_KHZ = 1000;
  localparam int SCL_LOW_MIN_NS = 500;
  localparam int SCL_HIGH_MIN_NS = 260;
  localparam int SCL_LOW_CYC = SCL_LOW_MIN_NS / CLK_PERIOD_NS;
  localparam int SCL_HIGH_CYC = SCL_HIGH_MIN_NS / CLK_PERIOD_NS;

  // Selectable 7-bit target addresses
  localparam logic [6:0] TGT_ADDR_0 = 7'h25;
  localparam logic [6:0] TGT_ADDR_1 = 7'h27;
  localparam logic [6:0] TGT_ADDR_2 = 7'h67;
  localparam logic [6:0] TGT_ADDR_3 = 7'h6B;

  // Direction bit of the address byte
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;

  // Byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Reset values
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [1:0] ADDR_SEL_RESET = 2'h0;

  // Write FIFO shape: {index, data}
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;

  // Packet states
  typedef enum logic [3:0] {
    PIT_IDLE,
    PIT_ADDR,
    PIT_ADDR_ACK,
    PIT_INDEX,
    PIT_INDEX_ACK,
    PIT_WDATA,
    PIT_WDATA_ACK,
    PIT_RDATA,
    PIT_RDATA_ACK
  } pit_state_t;

  // Address selected by the factory index
  function automatic logic [6:0] pit_target_addr(input logic [1:0] sel);
    logic [6:0] a;
    a = TGT_ADDR_0;
    if (sel == 2'h1) begin
      a = TGT_ADDR_1;
    end else if (sel == 2'h2) begin
      a = TGT_ADDR_2;
    end else if (sel == 2'h3) begin
      a = TGT_ADDR_3;
    end
    return a;
  endfunction

endpackage

`default_nettype wire

// file: design/pit_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a clear input.
  Assumes one clock; DEPTH is a power of two; output data is the
  flip-flop word at the read pointer.
*/
`timescale 1ns/1ps
`default_nettype none

module pit_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // Refuse shapes the pointer wrap cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_shape
    $error("pit_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } pit_fifo_state_t;

  pit_fifo_state_t st_reg;
  pit_fifo_state_t st_next;
  logic do_push;
  logic do_pop;

  // Honest flags from the occupancy count
  assign in_ready = (st_reg.count != CW'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data = st_reg.mem[st_reg.rptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  // Next state
  always_comb begin
    st_next = st_reg;
    if (do_push) begin
      st_next.mem[st_reg.wptr] = in_data;
      st_next.wptr = st_reg.wptr + PW'(1);
    end
    if (do_pop) begin
      st_next.rptr = st_reg.rptr + PW'(1);
    end
    if (do_push && !do_pop) begin
      st_next.count = st_reg.count + CW'(1);
    end else if (do_pop && !do_push) begin
      st_next.count = st_reg.count - CW'(1);
    end
    if (clear) begin
      st_next.wptr = '0;
      st_next.rptr = '0;
      st_next.count = '0;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

// file: design/pit_target.sv
/*
  I2C target port of the power-management device. Samples SCL and SDA
  with the core clock, filters spikes, decodes start/stop, addresses and
  bytes, queues register writes in a FIFO and fetches read bytes from the
  register side.
  Assumes: SDA pulled up outside; the register side answers a read
  request with data in the same cycle as rd_req; state inputs come from core_clk logic.
*/
// Functional notes
// [RQ1] The port is a target only and answers one 7-bit address chosen by the factory index.
// [RQ2] The address is one of 0x25, 0x27, 0x67 or 0x6B, and all other addresses are ignored.
// [RQ3] The address byte holds the address in bits 7..1 and the direction in bit 0, 0 write and 1 read.
// [RQ4] There is no inactivity timeout, so an unfinished packet waits until a later event clears it.
// [RQ5] A start condition at any moment drops the packet in progress and restarts at the address phase.
// [RQ6] Entry into deep sleep, voltage fault or thermal fault resets the packet machine and discards it.
// [RQ7] In the device RESET state the port stays silent and never drives SDA.
// [RQ8] The port works at any SCL rate from 0 up to 1 MHz.
// [RQ9] Spikes of up to 50 ns on SCL or SDA are filtered and never seen as edges, starts or stops.
// [RQ10] SDA is only ever pulled low and SCL is only an input.
// [RQ11] Entering RESET returns the port's state to defaults and drops queued writes.
// [RQ12] The port stays alive in the sleep state.
// [RQ13] Only a matching address is acknowledged; the first write byte is the index, later bytes data.
// [RQ14] A read is an index write, repeated start and read address; the master ends it with a nack and stop.
`timescale 1ns/1ps
`default_nettype none

module pit_target
  import pit_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] factory_configuration_index,
  input wire logic dev_in_reset,
  input wire logic deep_low_power_mode,
  input wire logic voltage_fault_state,
  input wire logic thermal_fault_state,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_index,
  output logic [7:0] wr_data,
  output logic rd_req,
  output logic [7:0] rd_index,
  input wire logic [7:0] rd_data,
  output logic busy
);

  // The filter counter is two bits wide
  if (FILT_CYC < 2 || FILT_CYC > 3) begin : g_bad_filter
    $error("pit_target: filter length out of range");
  end

  localparam logic [1:0] FILT_LAST = 2'(FILT_CYC - 1);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_f;
    logic sda_f;
    logic [1:0] scl_cnt;
    logic [1:0] sda_cnt;
    logic [2:0] flt_prev;
    logic [1:0] addr_sel;
    logic strap_done;
    pit_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [7:0] index;
    logic [7:0] rd_buf;
    logic rd_req;
    logic sda_drv;
    logic push_valid;
    logic [15:0] push_word;
  } pit_state_reg_t;

  pit_state_reg_t st_reg;
  pit_state_reg_t st_next;

  logic scl_acc;
  logic sda_acc;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic flt_entry;
  logic fifo_in_ready;
  logic [15:0] fifo_out;

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling and spike filter

  // Accept a new level only after it persists past the spike width
  assign scl_acc = (st_reg.scl_s2 != st_reg.scl_f) && (st_reg.scl_cnt == FILT_LAST); // [RQ9]
  assign sda_acc = (st_reg.sda_s2 != st_reg.sda_f) && (st_reg.sda_cnt == FILT_LAST); // [RQ9]

  // Edges and bus conditions from filtered levels, no rate floor [RQ8]
  assign scl_rise = scl_acc && st_reg.scl_s2;
  assign scl_fall = scl_acc && !st_reg.scl_s2;
  assign start_det = sda_acc && !st_reg.sda_s2 && st_reg.scl_f && !scl_acc;
  assign stop_det = sda_acc && st_reg.sda_s2 && st_reg.scl_f && !scl_acc;

  // Entry into a state that must flush the port
  assign flt_entry = |({deep_low_power_mode, voltage_fault_state, thermal_fault_state} & ~st_reg.flt_prev);

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;
    st_next.rd_req = 1'b0;
    st_next.push_valid = 1'b0;

    // Two-stage synchronisers
    st_next.scl_s1 = scl_in;
    st_next.scl_s2 = st_reg.scl_s1;
    st_next.sda_s1 = sda_in;
    st_next.sda_s2 = st_reg.sda_s1;

    // Persistence counters
    if (st_reg.scl_s2 == st_reg.scl_f || scl_acc) begin
      st_next.scl_cnt = 2'h0;
    end else begin
      st_next.scl_cnt = st_reg.scl_cnt + 2'h1;
    end
    if (scl_acc) begin
      st_next.scl_f = st_reg.scl_s2;
    end
    if (st_reg.sda_s2 == st_reg.sda_f || sda_acc) begin
      st_next.sda_cnt = 2'h0;
    end else begin
      st_next.sda_cnt = st_reg.sda_cnt + 2'h1;
    end
    if (sda_acc) begin
      st_next.sda_f = st_reg.sda_s2;
    end

    st_next.flt_prev = {deep_low_power_mode, voltage_fault_state, thermal_fault_state};

    // Factory index caught after reset and during device RESET
    if (dev_in_reset || !st_reg.strap_done) begin
      st_next.addr_sel = factory_configuration_index; // [RQ1]
      st_next.strap_done = 1'b1;
    end

    // Read data is taken in the same cycle as rd_req
    if (st_reg.rd_req) begin
      st_next.rd_buf = rd_data;
    end

    // Packet machine; no timer anywhere, waits on bus events, device RESET or state entry [RQ4]
    if (dev_in_reset) begin
      st_next.state = PIT_IDLE; // [RQ7] [RQ11]
      st_next.sda_drv = 1'b0;
      st_next.bitcnt = 4'h0;
      st_next.index = INDEX_RESET;
    end else if (flt_entry) begin
      st_next.state = PIT_IDLE; // [RQ6]
      st_next.sda_drv = 1'b0;
      st_next.bitcnt = 4'h0;
    end else if (start_det) begin
      st_next.state = PIT_ADDR; // [RQ5]
      st_next.sda_drv = 1'b0;
      st_next.bitcnt = 4'h0;
    end else if (stop_det) begin
      st_next.state = PIT_IDLE;
      st_next.sda_drv = 1'b0;
      st_next.bitcnt = 4'h0;
    end else begin
      case (st_reg.state)
        PIT_ADDR, PIT_INDEX, PIT_WDATA: begin
          if (scl_rise) begin
            st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_f};
            st_next.bitcnt = st_reg.bitcnt + 4'h1;
          end else if (scl_fall && st_reg.bitcnt == BYTE_BITS) begin
            st_next.bitcnt = 4'h0;
            if (st_reg.state == PIT_ADDR) begin
              // Address in bits 7..1, direction in bit 0 [RQ3]
              if (st_reg.shreg[7:1] == pit_target_addr(st_reg.addr_sel)) begin
                st_next.rw = st_reg.shreg[0]; // [RQ2] [RQ13]
                st_next.sda_drv = 1'b1;
                st_next.state = PIT_ADDR_ACK;
              end else begin
                st_next.state = PIT_IDLE; // [RQ2]
              end
            end else if (st_reg.state == PIT_INDEX) begin
              st_next.index = st_reg.shreg; // [RQ13]
              st_next.sda_drv = 1'b1;
              st_next.state = PIT_INDEX_ACK;
            end else if (fifo_in_ready) begin
              st_next.push_valid = 1'b1; // [RQ13]
              st_next.push_word = {st_reg.index, st_reg.shreg};
              st_next.index = st_reg.index + 8'h01;
              st_next.sda_drv = 1'b1;
              st_next.state = PIT_WDATA_ACK;
            end else begin
              st_next.state = PIT_IDLE; // Full queue: nack the byte
            end
          end
        end
        PIT_ADDR_ACK, PIT_RDATA_ACK: begin
          if (scl_rise) begin
            if (st_reg.state == PIT_RDATA_ACK && st_reg.sda_f) begin
              st_next.state = PIT_IDLE; // [RQ14]
            end else if (st_reg.rw == DIR_READ) begin
              st_next.rd_req = 1'b1; // [RQ14]
            end
          end else if (scl_fall) begin
            st_next.bitcnt = 4'h0;
            if (st_reg.rw == DIR_READ) begin
              // First read bit goes out on this falling edge
              st_next.shreg = st_reg.rd_buf;
              st_next.sda_drv = !st_reg.rd_buf[7];
              st_next.index = st_reg.index + 8'h01;
              st_next.state = PIT_RDATA;
            end else begin
              st_next.sda_drv = 1'b0;
              st_next.state = PIT_INDEX;
            end
          end
        end
        PIT_INDEX_ACK, PIT_WDATA_ACK: begin
          if (scl_fall) begin
            st_next.sda_drv = 1'b0;
            st_next.state = PIT_WDATA;
          end
        end
        PIT_RDATA: begin
          if (scl_fall) begin
            if (st_reg.bitcnt == LAST_BIT) begin
              st_next.bitcnt = 4'h0;
              st_next.sda_drv = 1'b0;
              st_next.state = PIT_RDATA_ACK;
            end else begin
              st_next.bitcnt = st_reg.bitcnt + 4'h1;
              st_next.shreg = {st_reg.shreg[6:0], 1'b0};
              st_next.sda_drv = !st_reg.shreg[6];
            end
          end
        end
        default: begin
          st_next.sda_drv = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.scl_s1 <= 1'b1;
      st_reg.scl_s2 <= 1'b1;
      st_reg.sda_s1 <= 1'b1;
      st_reg.sda_s2 <= 1'b1;
      st_reg.scl_f <= 1'b1;
      st_reg.sda_f <= 1'b1;
      st_reg.addr_sel <= ADDR_SEL_RESET;
      st_reg.index <= INDEX_RESET;
      st_reg.state <= PIT_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write queue toward the register side

  pit_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(dev_in_reset), // [RQ11]
    .in_valid(st_reg.push_valid),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open drain: only low is driven; sleep does not gate the port [RQ10] [RQ12]
  assign sda_out = 1'b0;
  assign sda_oe_n = !st_reg.sda_drv;
  assign wr_index = fifo_out[15:8];
  assign wr_data = fifo_out[7:0];
  assign rd_req = st_reg.rd_req;
  assign rd_index = st_reg.index;
  assign busy = (st_reg.state != PIT_IDLE);

endmodule

`default_nettype wire

// file: sim/pit_target_checker.sv
/*
  Port checker of the I2C target, bound into pit_target.
  Assumes one core clock domain and the synchronous reset_n.
*/
`timescale 1ns/1ps
`default_nettype none

module pit_target_checker
  import pit_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic dev_in_reset,
  input wire logic deep_low_power_mode,
  input wire logic voltage_fault_state,
  input wire logic thermal_fault_state,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [7:0] wr_index,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  input wire logic [7:0] rd_index,
  input wire logic busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////
  // Pin, reset and flush behaviour
  chk_sda_low_only: assert property (!sda_oe_n |-> sda_out == 1'b0 && busy)
    else $error("sda pulled outside a packet or driven high");
  chk_idle_release: assert property (!busy ##1 !busy |-> sda_oe_n)
    else $error("sda pulled while idle");
  chk_ack_after_fall: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 2) && !$past(scl_in, 3))
    else $error("sda pulled without settled scl low");
  chk_reset_silent: assert property (dev_in_reset ##1 dev_in_reset |-> sda_oe_n && !busy)
    else $error("port active in reset state");
  chk_reset_fifo: assert property (dev_in_reset ##1 dev_in_reset |-> !wr_valid)
    else $error("queued writes kept in reset state");
  chk_fault_flush: assert property ($rose(deep_low_power_mode) || $rose(voltage_fault_state)
    || $rose(thermal_fault_state) |-> ##[1:2] (!busy && sda_oe_n))
    else $error("packet not flushed on state entry");

  ////////////////////////////////////////////////////////////////////////
  // Register side handshakes
  chk_rd_pulse: assert property (rd_req |-> busy ##1 !rd_req)
    else $error("read request not a single pulse");
  chk_rd_index: assert property (rd_req |=> $stable(rd_index))
    else $error("read index moved during fetch");
  chk_wr_hold: assert property (wr_valid && !wr_ready && !dev_in_reset |=>
    wr_valid && $stable({wr_index, wr_data}))
    else $error("write word changed while stalled");
endmodule

bind pit_target pit_target_checker #(.DEPTH(DEPTH)) i_chk (.core_clk, .reset_n, .scl_in, .sda_out,
  .sda_oe_n, .dev_in_reset, .deep_low_power_mode, .voltage_fault_state, .thermal_fault_state,
  .wr_valid, .wr_ready, .wr_index, .wr_data, .rd_req, .rd_index, .busy);

`default_nettype wire

// file: sim/pit_ctl_model.sv
/*
  Behavioural I2C controller driving SCL and the open-drain SDA.
  Assumes the bench resolves the SDA wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module pit_ctl_model (
  output var logic scl,
  output var logic sda_rel,
  input wire logic sda_wire
);
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // One clock at 1 MHz: low 600 ns, high 400 ns
  task automatic bit_io(input logic b, output logic s);
    #300 sda_rel = b; // Only ever pulls low
    #300 scl = 1'b1;
    #200 s = sda_wire;
    #200 scl = 1'b0;
  endtask

  // Start or repeated start
  task automatic start();
    #300 sda_rel = 1'b1;
    #300 scl = 1'b1;
    #300 sda_rel = 1'b0;
    #300 scl = 1'b0;
  endtask

  // Stop, SCL left standing high
  task automatic stop();
    #300 sda_rel = 1'b0;
    #300 scl = 1'b1;
    #300 sda_rel = 1'b1;
  endtask

  // Byte out MSB first, then ack clock
  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack_n);
  endtask

  // Byte in, nack on the last one
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask

  // 40 ns spikes on an idle bus
  task automatic glitch();
    #40 sda_rel = 1'b0;
    #40 sda_rel = 1'b1;
    #40 scl = 1'b0;
    #40 scl = 1'b1;
  endtask
endmodule

`default_nettype wire

// file: sim/tb.sv
/*
  Self-checking bench of pit_target with a controller model.
  Assumes the register side answers reads with rd_index xor a key.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pit_pkg::*;
  localparam int DEPTH = 16;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic dev_in_reset = 1'b0;
  logic wr_ready = 1'b0;
  logic [1:0] factory_configuration_index = 2'h0;
  logic [2:0] flt = 3'h0;
  logic [7:0] rd_key = 8'h00;
  logic [7:0] rd_data;
  wire scl_in;
  wire sda_rel;
  wire sda_in;
  logic sda_out, sda_oe_n, wr_valid, rd_req, busy;
  logic [7:0] wr_index, wr_data, rd_index;
  int n_errors = 0;
  int samples_checked = 0;
  logic [6:0] addr_tab [4] = '{7'h25, 7'h27, 7'h67, 7'h6B};

  // Wire with pull-up, register side answer, clock
  assign sda_in = sda_rel & (sda_oe_n | sda_out);
  assign rd_data = rd_index ^ rd_key;
  always #25 core_clk = ~core_clk;

  pit_ctl_model i_ctl (.scl(scl_in), .sda_rel(sda_rel), .sda_wire(sda_in));
  pit_target #(.DEPTH(DEPTH)) i_dut (.core_clk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe_n,
    .factory_configuration_index, .dev_in_reset, .deep_low_power_mode(flt[0]),
    .voltage_fault_state(flt[1]), .thermal_fault_state(flt[2]), .wr_valid, .wr_ready,
    .wr_index, .wr_data, .rd_req, .rd_index, .rd_data, .busy);

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Byte the register side hands back for an index
  function automatic logic [7:0] exp_rd(input logic [7:0] i);
    return i ^ rd_key;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic send(input logic [7:0] b, input logic exp_n, input string what);
    logic a;
    i_ctl.wr_byte(b, a);
    check(what, 16'(a), 16'(exp_n));
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] idx, d, input logic exp_n);
    i_ctl.start();
    send({a, DIR_WRITE}, exp_n, "addr_ack");
    if (!exp_n) begin
      send(idx, 1'b0, "index_ack");
      send(d, 1'b0, "data_ack");
    end
    i_ctl.stop();
  endtask

  task automatic pop(input logic [7:0] idx, d);
    step(1);
    check("wr_valid", 16'(wr_valid), 16'h1);
    check("wr_word", {wr_index, wr_data}, {idx, d});
    wr_ready = 1'b1;
    step(1);
    wr_ready = 1'b0;
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] idx, d, b0, b1;
    logic a;
    logic [7:0] q [DEPTH + 1];
    void'($urandom(62));
    rd_key = 8'($urandom);
    step(4);
    reset_n = 1'b1;
    step(6);
    // Every factory address, plus a foreign one
    for (int s = 0; s < 4; s++) begin
      factory_configuration_index = 2'(s);
      dev_in_reset = 1'b1;
      step(2);
      dev_in_reset = 1'b0;
      step(4);
      idx = 8'($urandom);
      d = 8'($urandom);
      wr_reg(addr_tab[s], idx, d, 1'b0);
      pop(idx, d);
      wr_reg(addr_tab[(s + 1) % 4], idx, d, 1'b1);
      step(2);
      check("wr_valid", 16'(wr_valid), 16'h0);
    end
    // Index write, repeated start, two reads
    idx = 8'($urandom);
    i_ctl.start();
    send({addr_tab[3], DIR_WRITE}, 1'b0, "addr_ack");
    send(idx, 1'b0, "index_ack");
    i_ctl.start();
    send({addr_tab[3], DIR_READ}, 1'b0, "raddr_ack");
    i_ctl.rd_byte(1'b0, b0);
    i_ctl.rd_byte(1'b1, b1);
    i_ctl.stop();
    check("rd_byte0", 16'(b0), 16'(exp_rd(idx)));
    check("rd_byte1", 16'(b1), 16'(exp_rd(8'(idx + 8'h01))));
    // Start in mid-byte restarts the packet
    i_ctl.start();
    send({addr_tab[3], DIR_WRITE}, 1'b0, "addr_ack");
    i_ctl.bit_io(1'b0, a);
    i_ctl.bit_io(1'b1, a);
    idx = 8'($urandom);
    d = 8'($urandom);
    wr_reg(addr_tab[3], idx, d, 1'b0);
    pop(idx, d);
    // Stalled packet waits, then each state entry flushes it
    for (int f = 0; f < 3; f++) begin
      i_ctl.start();
      send({addr_tab[3], DIR_WRITE}, 1'b0, "addr_ack");
      step(400);
      check("busy_hold", 16'(busy), 16'h1);
      flt[f] = 1'b1;
      step(3);
      check("busy_flush", 16'({busy, sda_oe_n}), 16'h1);
      send(8'h05, 1'b1, "flushed_ack");
      i_ctl.stop();
      flt = 3'h0;
      step(4);
    end
    // Spikes on an idle bus
    i_ctl.glitch();
    step(10);
    check("busy_spike", 16'(busy), 16'h0);
    // Fill the write queue until refused, drain most of it
    idx = 8'($urandom);
    i_ctl.start();
    send({addr_tab[3], DIR_WRITE}, 1'b0, "addr_ack");
    send(idx, 1'b0, "index_ack");
    for (int i = 0; i <= DEPTH; i++) begin
      q[i] = 8'($urandom);
      send(q[i], 1'(i == DEPTH), "fill_ack");
    end
    i_ctl.stop();
    for (int i = 0; i < DEPTH - 2; i++) begin
      pop(8'(idx + 8'(i)), q[i]);
    end
    // Device reset state clears the queue and silences the port
    dev_in_reset = 1'b1;
    step(3);
    check("wr_valid_rst", 16'(wr_valid), 16'h0);
    wr_reg(addr_tab[3], idx, d, 1'b1);
    check("busy_rst", 16'(busy), 16'h0);
    dev_in_reset = 1'b0;
    step(4);
    conclude();
  end

  // Watchdog, about four times the expected run
  initial begin
    #2_000_000;
    n_errors++;
    conclude();
  end
endmodule

`default_nettype wire
